// [rtl/vbs_pkg.sv]
// Purpose: Constants for the byte-synchronous tributary sink
// Assumes: 100 MHz aclk, container link sampled as plain inputs
// Notes:   Offsets are AXI4-Lite byte addresses
// Overview of operation
// - Compare accepted label bits five to seven with fixed code 100.
// - Accept label after persistence; flag mismatch; report accepted label.
// - Recovered tributary keeps frequency within 4.6 ppm of its source.
// - Write tributary bits into elastic store on gapped container clock.
// - Read store with smoothed 2048 kHz clock following remote tributary rate.
// - Smoothing keeps pointer-induced output jitter within interface limits.
// - Store sized so no bit errors under specified jitter and offset.
// - After frequency step, errors stop within about one second.
// - Inactive: output all-ones and suppress all status reporting except server_fail_out.
// - Fixed-stuff bytes are dropped, never passed to the tributary.
// - Trail fail or mismatch: server fail and all-ones within 250 us.
// - During all-ones the output clock stays within 2048 kHz 50 ppm.
// - Container is four groups: overhead byte, stuff byte, 32 timeslots, stuff byte.
package vbs_pkg;
    // ==========================================================
    // Container layout and label
    localparam logic [2:0] EXP_LABEL     = 3'h4;
    localparam logic [2:0] PERSIST_LAST  = 3'h4;
    localparam logic [2:0] LBL_BIT_LO    = 3'h4;
    localparam logic [2:0] LBL_BIT_HI    = 3'h6;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [5:0] TS_FIRST      = 6'h02;
    localparam logic [5:0] TS_LAST       = 6'h21;
    localparam logic [5:0] GRP_LAST      = 6'h22;
    // ==========================================================
    // Timing
    localparam int         SYS_CLK_KHZ   = 100000;
    localparam int         TRIB_KHZ      = 2048;
    localparam int         TRIM_PPM      = 40;
    localparam int         AIS_US        = 250;
    localparam int         AIS_CYC       = AIS_US * (SYS_CLK_KHZ / 1000);
    localparam logic [31:0] NCO_NOM      =
        32'((64'h1_0000_0000 * 64'(2 * TRIB_KHZ)) / 64'(SYS_CLK_KHZ));
    localparam logic [31:0] NCO_TRIM     =
        32'((64'(NCO_NOM) * 64'(TRIM_PPM)) / 64'd1000000);
    // ==========================================================
    // Elastic store
    localparam int         FIFO_DEPTH    = 16;
    localparam logic [4:0] FIFO_HALF     = 5'h08;
    // ==========================================================
    // Register map
    localparam logic [3:0] CTRL_OFS      = 4'h0;
    localparam logic [3:0] STAT_OFS      = 4'h4;
    localparam logic       CTRL_ACT_RST  = 1'b1;
    localparam int         ST_CAUSE      = 3;
    localparam int         ST_SSF        = 4;
    localparam int         ST_OVF        = 5;
    localparam int         ST_LVL        = 8;
    localparam logic [1:0] RESP_OK       = 2'h0;
    localparam logic [1:0] RESP_ERR      = 2'h2;
endpackage : vbs_pkg

// [rtl/vbs_tributary_sink.sv]
// Purpose: VC-12 byte-synchronous tributary sink with elastic store
// Assumes: Link pins are asynchronous to aclk and pass two flip-flops
// Notes:   Output clock is an NCO tick pair trimmed by store fill level
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

// ==============================================================
// Elastic store
module vbs_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } vbs_fifo_state_type;
    vbs_fifo_state_type q, d;
    assign level     = q.wp - q.rp;
    assign in_ready  = (level != (AW + 1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = q.mem[q.rp[AW-1:0]];
    always_comb begin
        d = q;
        if (in_valid && in_ready) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp                = q.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rp = q.rp + 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : vbs_fifo

// ==============================================================
// Sink top
module vbs_tributary_sink #(
    parameter int AIS_LIMIT_CYC = vbs_pkg::AIS_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        container_data_in,
    input  wire logic        container_gapped_clock_in,
    input  wire logic        container_frame_start_in,
    input  wire logic        upstream_trail_fail_in,
    output logic             tributary_data_out,
    output logic             tributary_clock_out,
    output logic             server_fail_out,
    output logic             label_mismatch_cause_out,
    output logic [2:0]       accepted_label_out
);
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic        ck3;
        logic [2:0]  bit_n;
        logic [5:0]  byte_n;
        logic [1:0]  grp;
        logic [2:0]  lbl_sh;
        logic [2:0]  cand;
        logic [2:0]  pcnt;
        logic [2:0]  acc;
        logic        push;
        logic        push_bit;
        logic [31:0] phase;
        logic [31:0] inc;
        logic        clk_o;
        logic        data_o;
        logic        ssf_o;
        logic        cause_o;
        logic [2:0]  acc_o;
        logic        act;
        logic        ovf;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_held;
        logic        w_held;
        logic [3:0]  awaddr;
        logic [31:0] wdata;
        logic        wstrb0;
    } vbs_state_type;
    vbs_state_type q, d;
    logic        f_in_ready;
    logic        f_out_valid;
    logic        f_out_ready;
    logic        f_out_data;
    logic [4:0]  f_level;
    logic        link_edge;
    logic        tsf;
    logic        label_mismatch_defect;
    logic        ais;
    logic        nco_tick;
    logic [32:0] nco_sum;
    logic [31:0] stat_word;
    logic [2:0]  cb;
    logic [5:0]  cbyte;
    logic [1:0]  cg;
    // s1/s2 bit order: {trail fail, frame start, data, gapped clock}
    assign link_edge   = q.s2[0] && !q.ck3;
    assign tsf         = q.s2[3];
    assign label_mismatch_defect = (q.acc != vbs_pkg::EXP_LABEL);
    assign ais         = !q.act || tsf || label_mismatch_defect;
    assign nco_sum     = {1'b0, q.phase} + {1'b0, q.inc};
    assign nco_tick    = nco_sum[32];
    assign f_out_ready = nco_tick && q.clk_o;
    assign stat_word   = {19'h0, f_level, 2'h0, q.ovf, q.ssf_o, q.cause_o, q.acc_o};
    vbs_fifo #(
        .WIDTH (1),
        .DEPTH (vbs_pkg::FIFO_DEPTH)
    ) u_store (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (q.push),
        .in_ready  (f_in_ready),
        .in_data   (q.push_bit),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data),
        .level     (f_level)
    );
    always_comb begin
        d      = q;
        d.s1   = {upstream_trail_fail_in, container_frame_start_in,
                  container_data_in, container_gapped_clock_in};
        d.s2   = q.s1;
        d.ck3  = q.s2[0];
        d.push = 1'b0;
        cb     = q.bit_n;
        cbyte  = q.byte_n;
        cg     = q.grp;
        // ==========================================================
        // Container framing and label capture
        if (link_edge) begin
            if (q.s2[2]) begin
                cb    = '0;
                cbyte = '0;
                cg    = '0;
            end
            if (cbyte >= vbs_pkg::TS_FIRST && cbyte <= vbs_pkg::TS_LAST) begin
                d.push     = 1'b1;
                d.push_bit = q.s2[1];
            end
            if (cg == 2'h0 && cbyte == 6'h00) begin
                if (cb >= vbs_pkg::LBL_BIT_LO && cb <= vbs_pkg::LBL_BIT_HI) begin
                    d.lbl_sh = {q.lbl_sh[1:0], q.s2[1]};
                end
                if (cb == vbs_pkg::BIT_LAST) begin
                    if (q.lbl_sh != q.cand) begin
                        d.cand = q.lbl_sh;
                        d.pcnt = '0;
                    end else if (q.pcnt != vbs_pkg::PERSIST_LAST) begin
                        d.pcnt = q.pcnt + 3'h1;
                    end
                    if (d.pcnt == vbs_pkg::PERSIST_LAST) begin
                        d.acc = d.cand;
                    end
                end
            end
            if (cb == vbs_pkg::BIT_LAST) begin
                d.bit_n = '0;
                if (cbyte == vbs_pkg::GRP_LAST) begin
                    d.byte_n = '0;
                    d.grp    = cg + 2'h1;
                end else begin
                    d.byte_n = cbyte + 6'h01;
                end
            end else begin
                d.bit_n  = cb + 3'h1;
                d.byte_n = cbyte;
                d.grp    = cg;
            end
        end
        // ==========================================================
        // Smoothed read clock, trimmed by fill level
        if (f_level > vbs_pkg::FIFO_HALF) begin
            d.inc = vbs_pkg::NCO_NOM + vbs_pkg::NCO_TRIM;
        end else if (f_level < vbs_pkg::FIFO_HALF) begin
            d.inc = vbs_pkg::NCO_NOM - vbs_pkg::NCO_TRIM;
        end else begin
            d.inc = vbs_pkg::NCO_NOM;
        end
        d.phase = nco_sum[31:0];
        if (nco_tick) begin
            d.clk_o = !q.clk_o;
            if (q.clk_o) begin
                d.data_o = ais || !f_out_valid || f_out_data;
            end
        end
        // ==========================================================
        // Consequent actions and reporting
        d.ssf_o   = tsf || label_mismatch_defect;
        d.cause_o = q.act && label_mismatch_defect && !tsf;
        d.acc_o   = q.act ? q.acc : 3'h0;
        // ==========================================================
        // AXI4-Lite slave
        if (s_axi_awvalid && q.awready) begin
            d.aw_held = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_held = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (d.aw_held && d.w_held && !q.bvalid) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = vbs_pkg::RESP_OK;
            if (d.awaddr == vbs_pkg::CTRL_OFS) begin
                if (d.wstrb0) begin
                    d.act = d.wdata[0];
                end
            end else if (d.awaddr == vbs_pkg::STAT_OFS) begin
                if (d.wstrb0 && d.wdata[vbs_pkg::ST_OVF]) begin
                    d.ovf = 1'b0;
                end
            end else begin
                d.bresp = vbs_pkg::RESP_ERR;
            end
        end
        d.awready = !d.aw_held && !d.bvalid;
        d.wready  = !d.w_held && !d.bvalid;
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = vbs_pkg::RESP_OK;
            if (s_axi_araddr == vbs_pkg::CTRL_OFS) begin
                d.rdata = {31'h0, q.act};
            end else if (s_axi_araddr == vbs_pkg::STAT_OFS) begin
                d.rdata = q.act ? stat_word : 32'h0;
            end else begin
                d.rdata = 32'h0;
                d.rresp = vbs_pkg::RESP_ERR;
            end
        end
        d.arready = !d.rvalid;
        // Overflow set after the clear so a same-cycle event wins
        if (q.push && !f_in_ready) begin
            d.ovf = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q        <= '0;
            q.act    <= vbs_pkg::CTRL_ACT_RST;
            q.data_o <= 1'b1;
            q.inc    <= vbs_pkg::NCO_NOM;
        end else begin
            q <= d;
        end
    end
    assign s_axi_awready            = q.awready;
    assign s_axi_wready             = q.wready;
    assign s_axi_bresp              = q.bresp;
    assign s_axi_bvalid             = q.bvalid;
    assign s_axi_arready            = q.arready;
    assign s_axi_rdata              = q.rdata;
    assign s_axi_rresp              = q.rresp;
    assign s_axi_rvalid             = q.rvalid;
    assign tributary_data_out       = q.data_o;
    assign tributary_clock_out      = q.clk_o;
    assign server_fail_out          = q.ssf_o;
    assign label_mismatch_cause_out = q.cause_o;
    assign accepted_label_out       = q.acc_o;
    // ==============================================================
    // Checks
    default clocking cb_chk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [15:0] ais_wait_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !ais || tributary_data_out) begin
            ais_wait_q <= '0;
        end else begin
            ais_wait_q <= ais_wait_q + 16'h0001;
        end
    end

    property p_ssf;
        ($past(upstream_trail_fail_in, 2) || q.acc != vbs_pkg::EXP_LABEL) |=> server_fail_out;
    endproperty
    a_ssf: assert property (p_ssf) else $error("server fail missing");
    property p_ais_time;
        32'(ais_wait_q) < AIS_LIMIT_CYC;
    endproperty
    a_ais_time: assert property (p_ais_time) else $error("all-ones late");
    property p_inactive;
        !q.act |=> !label_mismatch_cause_out && accepted_label_out == 3'h0;
    endproperty
    a_inactive: assert property (p_inactive) else $error("status leak");
    property p_cause;
        label_mismatch_cause_out |-> $past(label_mismatch_defect) && !$past(tsf);
    endproperty
    a_cause: assert property (p_cause) else $error("bad cause");
    property p_accept;
        $changed(q.acc) |-> q.pcnt == vbs_pkg::PERSIST_LAST;
    endproperty
    a_accept: assert property (p_accept) else $error("label not persistent");
    property p_stuff;
        q.push |-> $past(q.byte_n) >= vbs_pkg::TS_FIRST || $past(q.s2[2]);
    endproperty
    a_stuff: assert property (p_stuff) else $error("stuff byte stored");
    property p_clk_steady;
        $changed(tributary_clock_out) |=> $stable(tributary_clock_out)[*8];
    endproperty
    a_clk_steady: assert property (p_clk_steady) else $error("clock too fast");
    property p_trim;
        (f_level > vbs_pkg::FIFO_HALF) |=> q.inc == vbs_pkg::NCO_NOM + vbs_pkg::NCO_TRIM;
    endproperty
    a_trim: assert property (p_trim) else $error("no speed-up");
    property p_ais_data;
        (nco_tick && q.clk_o && ais) |=> tributary_data_out ##1 tributary_clock_out == 1'b0;
    endproperty
    a_ais_data: assert property (p_ais_data) else $error("data not all-ones");

    c_accept: cover property ($changed(q.acc));
    c_full:   cover property (!f_in_ready);
    c_ssf:    cover property ($rose(server_fail_out));
endmodule : vbs_tributary_sink

// [tb/vbs_container_src.sv]
// Purpose: Upstream path termination model sending short container frames
// Assumes: Frame start flags the first bit of the overhead byte
// Notes:   Link clock stands still low between frames, data line toggles there
`timescale 1ns/1ps
module vbs_container_src #(
    parameter int NBYTES = 10
) (
    input  wire logic       enable,
    input  wire logic [2:0] label,
    output logic            gclk,
    output logic            data,
    output logic            fstart
);
    logic [7:0] b;

    initial begin
        gclk = 1'b0;
        data = 1'b1;
        fstart = 1'b0;
        forever begin
            wait (enable);
            for (int i = 0; i < NBYTES; i++) begin
                // Overhead carries the label in bits 5 to 7, stuff byte is all ones
                b = (i == 0) ? {4'ha, label, 1'b1} : ((i == 1) ? 8'hff : 8'h00);
                for (int k = 7; k >= 0; k--) begin
                    data = b[k];
                    fstart = (i == 0) && (k == 7);
                    #62.5 gclk = 1'b1;
                    #62.5 gclk = 1'b0;
                end
            end
            fstart = 1'b0;
            data = ~data;
            #2000;
        end
    end
endmodule : vbs_container_src

// [tb/vbs_tributary_sink_test.sv]
// Purpose: Self-checking bench for the byte-synchronous tributary sink
// Assumes: Partner model feeds zero timeslots at 8 MHz link rate
// Notes:   Alarm limit shortened to 2000 cycles
`timescale 1ns/1ps
module vbs_tributary_sink_test;
    localparam int         LIM = 2000;
    localparam logic [1:0] OK  = vbs_pkg::RESP_OK;
    localparam logic [1:0] ERR = vbs_pkg::RESP_ERR;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0]  resp;
    } vbs_exp_type;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, tsf, link_en;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        gclk, cdata, fstart, tdata, tclk, ssf, cause;
    logic [2:0]  acc_label, link_label;
    int          bad_count, comparisons, seed;
    vbs_exp_type wq[$], rq[$], e;

    vbs_container_src u_src (.enable(link_en), .label(link_label), .gclk(gclk),
        .data(cdata), .fstart(fstart));
    vbs_tributary_sink #(.AIS_LIMIT_CYC(LIM)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .container_data_in(cdata), .container_gapped_clock_in(gclk),
        .container_frame_start_in(fstart), .upstream_trail_fail_in(tsf),
        .tributary_data_out(tdata), .tributary_clock_out(tclk), .server_fail_out(ssf),
        .label_mismatch_cause_out(cause), .accepted_label_out(acc_label));

    always #5 aclk = ~aclk;

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic stop_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic timeout(input string what);
        $display("ERROR %s expected done seen timeout", what);
        bad_count++;
        stop_test();
    endtask : timeout

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        wq.push_back('{d, 32'h0, r});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; bready !== 1'b0 || n == 0; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
            if (n > 50) timeout("write response");
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                            input logic [1:0] r);
        int n;
        rq.push_back('{d, m, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; rready !== 1'b0 || n == 0; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
            if (n > 50) timeout("read response");
        end
    endtask : axi_read

    task automatic wait_val(input string what, input int lim, input logic [2:0] v);
        int n;
        for (n = 0; (what == "label" ? acc_label : {2'b0, tdata}) !== v; n++) begin
            @(posedge aclk);
            if (n > lim) timeout(what);
        end
        comparisons++;
    endtask : wait_val

    // Counts output clock rises and the ones sampled at them
    task automatic measure(input int cyc, output int ones, output int edges);
        logic prev;
        ones = 0;
        edges = 0;
        prev = tclk;
        repeat (cyc) begin
            @(posedge aclk);
            if (tclk && !prev) begin
                edges++;
                ones += int'(tdata);
            end
            prev = tclk;
        end
    endtask : measure

    // Oldest noted response is compared when the answer is sampled
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            e = wq.pop_front();
            chk("bresp", {30'h0, e.resp}, {30'h0, bresp});
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            chk("rresp", {30'h0, e.resp}, {30'h0, rresp});
            chk("rdata", e.data, rdata & e.mask);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        int ones, edges;
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tsf, link_en} = '0;
        {awaddr, araddr, wdata, link_label} = '0;
        wstrb = 4'hf;
        seed = 32'hfea0;
        repeat (16) @(posedge aclk);
        chk("reset data", 32'h1, {31'h0, tdata});
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("server_fail_out", 32'h1, {31'h0, ssf});
        chk("label_mismatch_cause_out", 32'h1, {31'h0, cause});
        axi_read(vbs_pkg::CTRL_OFS, 32'h1, 32'h1, OK);
        axi_read(4'hc, 32'h0, 32'hffffffff, ERR);
        axi_write(4'h8, $random(seed), ERR);
        link_label <= 3'h4;
        link_en <= 1'b1;
        wait_val("label", 20000, 3'h4);
        repeat (10) @(posedge aclk);
        chk("server_fail_out", 32'h0, {31'h0, ssf});
        wait_val("data", LIM, 3'h0);
        measure(4000, ones, edges);
        chk("stuff ones", 32'h0, ones);
        chk("clock rises", 32'h1, {31'h0, edges >= 81 && edges <= 83});
        axi_read(vbs_pkg::STAT_OFS, 32'h24, 32'h3f, OK);
        tsf <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("server_fail_out", 32'h1, {31'h0, ssf});
        chk("label_mismatch_cause_out", 32'h0, {31'h0, cause});
        wait_val("data", LIM, 3'h1);
        measure(2000, ones, edges);
        chk("alarm ones", edges, ones);
        chk("alarm rises", 32'h1, {31'h0, edges >= 40 && edges <= 42});
        tsf <= 1'b0;
        wait_val("data", LIM, 3'h0);
        link_label <= 3'h2;
        wait_val("label", 20000, 3'h2);
        repeat (10) @(posedge aclk);
        chk("server_fail_out", 32'h1, {31'h0, ssf});
        chk("label_mismatch_cause_out", 32'h1, {31'h0, cause});
        wait_val("data", LIM, 3'h1);
        axi_write(vbs_pkg::CTRL_OFS, {$random(seed)} & 32'hfffffffe, OK);
        repeat (10) @(posedge aclk);
        chk("accepted_label_out", 32'h0, {29'h0, acc_label});
        chk("label_mismatch_cause_out", 32'h0, {31'h0, cause});
        axi_read(vbs_pkg::STAT_OFS, 32'h0, 32'hffffffff, OK);
        axi_write(vbs_pkg::CTRL_OFS, 32'h1, OK);
        wstrb <= 4'he;
        axi_write(vbs_pkg::CTRL_OFS, 32'h0, OK);
        wstrb <= 4'hf;
        axi_read(vbs_pkg::CTRL_OFS, 32'h1, 32'h1, OK);
        link_label <= 3'h4;
        wait_val("label", 20000, 3'h4);
        wait_val("data", LIM, 3'h0);
        axi_write(vbs_pkg::CTRL_OFS, 32'h0, OK);
        wait_val("data", LIM, 3'h1);
        axi_write(vbs_pkg::CTRL_OFS, 32'h1, OK);
        link_en <= 1'b0;
        repeat (3000) @(posedge aclk);
        chk("drained data", 32'h1, {31'h0, tdata});
        axi_write(vbs_pkg::STAT_OFS, 32'h20, OK);
        axi_read(vbs_pkg::STAT_OFS, 32'h04, 32'h1f3f, OK);
        stop_test();
    end
endmodule : vbs_tributary_sink_test
